// ---- src/rfa_pkg.sv ----
package rfa_pkg;
  // register byte offsets, one aligned word each
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_FILE = 8'h08;
  localparam logic [7:0] ADDR_HITS = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_OFFS = 8'h14;
  localparam logic [7:0] ADDR_PTR = 8'h18;
  localparam logic [7:0] ADDR_HIT = 8'h1C;
  // control word bit positions
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // record access mode codes in the low three parameter-2 bits
  localparam logic [2:0] MODE_NEXT = 3'h2;
  localparam logic [2:0] MODE_PREV = 3'h3;
  localparam logic [2:0] MODE_ABS = 3'h4;
  // target file codes in the upper five parameter-2 bits
  localparam logic [4:0] SFI_CURRENT = 5'h00;
  localparam logic [4:0] SFI_RFU = 5'h1F;
  localparam logic [7:0] REC_NONE = 8'h00;
  localparam logic [7:0] REC_FIRST = 8'h01;

  typedef enum logic [1:0] {OP_UPD_BIN, OP_READ_REC, OP_UPD_REC, OP_SEARCH} rfa_op_t;
  typedef enum logic [2:0] {
    ERR_NONE, ERR_ACCESS, ERR_MODE, ERR_END, ERR_NOT_PERM, ERR_FILE, ERR_RANGE
  } rfa_err_t;
  typedef enum logic [1:0] {START_FIRST, START_OFFSET, START_AFTER_VALUE} rfa_start_t;

  typedef struct packed {
    rfa_op_t op;
    logic [7:0] len;
    logic [7:0] p2;
    logic [7:0] p1;
  } rfa_cmd_t;
  typedef struct packed {
    logic [7:0] ind;
    logic [4:0] cur_fid;
    logic upd_ok;
    logic rd_ok;
    logic cyclic;
    logic [7:0] nrec;
  } rfa_file_t;
  typedef struct packed {
    logic [4:0] fid;
    rfa_err_t err;
    logic renum;
    logic [7:0] cnt;
    logic [7:0] rec;
    logic ok;
    logic done;
  } rfa_status_t;
  typedef struct packed {
    rfa_start_t start;
    logic sfi_used;
    logic [4:0] short_file_id;
    logic [14:0] offset;
  } rfa_offs_t;

  // reset values
  localparam rfa_cmd_t CMD_RST = '0;
  localparam rfa_file_t FILE_RST = '0;
  localparam rfa_status_t STATUS_RST = '0;
  localparam rfa_offs_t OFFS_RST = '0;
  localparam logic [31:0] HITS_RST = 32'h0000_0000;
endpackage : rfa_pkg

// ---- src/rfa_engine.sv ----
// The placing of the registers and the AXI4-Lite register port were decided locally.
module rfa_engine (
  input wire logic aclk, // 50 MHz bus clock
  input wire logic aresetn, // synchronous reset
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address taken
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data taken
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response taken
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address taken
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data taken
);
  logic wr_acc_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rd_acc_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  rfa_pkg::rfa_cmd_t cmd_ff;
  rfa_pkg::rfa_file_t file_ff;
  logic [31:0] hits_ff;
  rfa_pkg::rfa_status_t status_ff;
  rfa_pkg::rfa_offs_t offs_ff;
  logic [31:0] found_ff;
  logic [7:0] ptr_mem_ff [32];
  logic exec_go;
  logic wr_fire;
  logic [4:0] fid;
  logic [7:0] cur_ptr;
  logic [2:0] mode;
  logic upd;
  rfa_pkg::rfa_status_t nxt_status;
  rfa_pkg::rfa_offs_t nxt_offs;
  logic ptr_we;
  logic [31:0] hits_v;
  logic [7:0] pop;
  logic search_back;
  logic exec_clr;
  logic [31:0] rd_word;
  logic rd_hit;

  // merge a write under its byte enables
  function automatic logic [31:0] wmerge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction : wmerge

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite handshakes: address and data are taken together, one at a time
  assign wr_fire = wr_acc_ff;
  assign exec_go = wr_fire && s_axi_awaddr == rfa_pkg::ADDR_CTRL && s_axi_wstrb[0]
                   && s_axi_wdata[rfa_pkg::CTRL_GO_BIT];
  assign exec_clr = wr_fire && s_axi_awaddr == rfa_pkg::ADDR_CTRL && s_axi_wstrb[0]
                    && s_axi_wdata[rfa_pkg::CTRL_CLR_BIT];
  assign rd_hit = s_axi_araddr <= rfa_pkg::ADDR_HIT && s_axi_araddr[1:0] == 2'h0;
  assign s_axi_awready = wr_acc_ff;
  assign s_axi_wready = wr_acc_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = rd_acc_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  // write channel; accept waits until the previous response has gone
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_acc_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= rfa_pkg::RESP_OKAY;
    end
    else
    begin
      wr_acc_ff <= s_axi_awvalid && s_axi_wvalid && !wr_acc_ff && !bvalid_ff;
      if (wr_fire)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= (s_axi_awaddr > rfa_pkg::ADDR_HIT || s_axi_awaddr[1:0] != 2'h0)
                    ? rfa_pkg::RESP_SLVERR : rfa_pkg::RESP_OKAY;
      end
      else if (s_axi_bready)
      begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // read channel; data is latched with the accept, so it stands until taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_acc_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= rfa_pkg::RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      rd_acc_ff <= s_axi_arvalid && !rd_acc_ff && !rvalid_ff;
      if (rd_acc_ff)
      begin
        rvalid_ff <= 1'b1;
        rresp_ff <= rd_hit ? rfa_pkg::RESP_OKAY : rfa_pkg::RESP_SLVERR;
        rdata_ff <= rd_word;
      end
      else if (s_axi_rready)
      begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // read mux; reading never disturbs state
  always_comb
  begin
    case (s_axi_araddr)
      rfa_pkg::ADDR_CMD: rd_word = {6'h00, cmd_ff};
      rfa_pkg::ADDR_FILE: rd_word = {8'h00, file_ff};
      rfa_pkg::ADDR_HITS: rd_word = hits_ff;
      rfa_pkg::ADDR_STATUS: rd_word = {5'h00, status_ff};
      rfa_pkg::ADDR_OFFS: rd_word = {9'h000, offs_ff};
      rfa_pkg::ADDR_PTR: rd_word = {24'h00_0000, ptr_mem_ff[file_ff.cur_fid]};
      rfa_pkg::ADDR_HIT: rd_word = found_ff;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // software registers; status-type words ignore writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmd_ff <= rfa_pkg::CMD_RST;
      file_ff <= rfa_pkg::FILE_RST;
      hits_ff <= rfa_pkg::HITS_RST;
    end
    else if (wr_fire)
    begin
      case (s_axi_awaddr)
        rfa_pkg::ADDR_CMD: cmd_ff <= 26'(wmerge({6'h00, cmd_ff}, s_axi_wdata, s_axi_wstrb));
        rfa_pkg::ADDR_FILE: file_ff <= 24'(wmerge({8'h00, file_ff}, s_axi_wdata, s_axi_wstrb));
        rfa_pkg::ADDR_HITS: hits_ff <= wmerge(hits_ff, s_axi_wdata, s_axi_wstrb);
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode and pointer arithmetic, evaluated in the go cycle
  always_comb
  begin
    upd = cmd_ff.op == rfa_pkg::OP_UPD_REC;
    search_back = cmd_ff.p2[1] ? file_ff.ind[0] : cmd_ff.p2[0];
    mode = cmd_ff.p2[2:0];
    fid = (cmd_ff.p2[7:3] == rfa_pkg::SFI_CURRENT) ? file_ff.cur_fid : cmd_ff.p2[7:3];
    cur_ptr = ptr_mem_ff[fid];
    nxt_status = rfa_pkg::STATUS_RST;
    nxt_status.fid = fid;
    nxt_status.cnt = cmd_ff.len;
    nxt_offs = rfa_pkg::OFFS_RST;
    ptr_we = 1'b0;
    hits_v = 32'h0000_0000;
    pop = 8'h00;
    // matches beyond the record count are dropped
    for (int i = 0; i < 32; i++)
    begin
      hits_v[i] = hits_ff[i] && (i < 32'(file_ff.nrec));
      pop = pop + 8'(hits_v[i]);
    end
    case (cmd_ff.op)
      rfa_pkg::OP_UPD_BIN:
      begin
        nxt_status.fid = file_ff.cur_fid;
        if (!cmd_ff.p1[7])
        begin
          nxt_offs.offset = {cmd_ff.p1[6:0], cmd_ff.p2};
        end
        else if (cmd_ff.p1[6:5] == 2'h0)
        begin
          nxt_offs.sfi_used = 1'b1;
          nxt_offs.short_file_id = cmd_ff.p1[4:0];
          nxt_offs.offset = {7'h00, cmd_ff.p2};
        end
        else
        begin
          nxt_status.err = rfa_pkg::ERR_MODE;
        end
        if (!file_ff.upd_ok)
        begin
          nxt_status.err = rfa_pkg::ERR_ACCESS;
        end
      end
      rfa_pkg::OP_SEARCH:
      begin
        if (!file_ff.rd_ok)
        begin
          nxt_status.err = rfa_pkg::ERR_ACCESS;
        end
        else if (!cmd_ff.p2[2] || cmd_ff.p2[1:0] == 2'h3)
        begin
          nxt_status.err = rfa_pkg::ERR_MODE;
        end
        else if (cmd_ff.p2[1])
        begin
          // enhanced: indication byte picks start place and direction
          nxt_offs.start = file_ff.ind[3] ? rfa_pkg::START_AFTER_VALUE : rfa_pkg::START_OFFSET;
        end
        nxt_status.cnt = (pop > cmd_ff.len) ? cmd_ff.len : pop;
        if (pop != 8'h00)
        begin
          ptr_we = 1'b1;
          for (int i = 0; i < 32; i++)
          begin
            if (hits_v[i] && (search_back || nxt_status.rec == rfa_pkg::REC_NONE))
            begin
              nxt_status.rec = 8'(i + 1);
            end
          end
        end
      end
      default:
      begin
        if (!(upd ? file_ff.upd_ok : file_ff.rd_ok))
        begin
          nxt_status.err = rfa_pkg::ERR_ACCESS;
        end
        else if (file_ff.cyclic && upd && mode != rfa_pkg::MODE_PREV)
        begin
          nxt_status.err = rfa_pkg::ERR_NOT_PERM;
        end
        else
        begin
          case (mode)
            rfa_pkg::MODE_ABS:
            begin
              // the pointer is only read here, never written
              nxt_status.rec = (cmd_ff.p1 == 8'h00) ? cur_ptr : cmd_ff.p1;
              if (cmd_ff.p1 > file_ff.nrec)
              begin
                nxt_status.err = rfa_pkg::ERR_RANGE;
              end
            end
            rfa_pkg::MODE_NEXT:
            begin
              ptr_we = 1'b1;
              if (cur_ptr == rfa_pkg::REC_NONE)
              begin
                nxt_status.rec = rfa_pkg::REC_FIRST;
              end
              else if (cur_ptr >= file_ff.nrec)
              begin
                if (file_ff.cyclic)
                begin
                  nxt_status.rec = rfa_pkg::REC_FIRST;
                end
                else
                begin
                  nxt_status.err = rfa_pkg::ERR_END;
                end
              end
              else
              begin
                nxt_status.rec = cur_ptr + 8'h01;
              end
            end
            rfa_pkg::MODE_PREV:
            begin
              ptr_we = 1'b1;
              if (file_ff.cyclic && upd)
              begin
                nxt_status.rec = rfa_pkg::REC_FIRST;
                nxt_status.renum = 1'b1;
              end
              else if (cur_ptr == rfa_pkg::REC_NONE)
              begin
                nxt_status.rec = file_ff.nrec;
              end
              else if (cur_ptr == rfa_pkg::REC_FIRST)
              begin
                if (file_ff.cyclic)
                begin
                  nxt_status.rec = file_ff.nrec;
                end
                else
                begin
                  nxt_status.err = rfa_pkg::ERR_END;
                end
              end
              else
              begin
                nxt_status.rec = cur_ptr - 8'h01;
              end
            end
            default: nxt_status.err = rfa_pkg::ERR_MODE;
          endcase
          if (nxt_status.err == rfa_pkg::ERR_NONE && nxt_status.rec == rfa_pkg::REC_NONE)
          begin
            nxt_status.err = rfa_pkg::ERR_RANGE;
          end
        end
      end
    endcase
    if (cmd_ff.op != rfa_pkg::OP_UPD_BIN && fid == rfa_pkg::SFI_RFU)
    begin
      nxt_status.err = rfa_pkg::ERR_FILE;
    end
    // a refused command moves no pointer and moves no data
    if (nxt_status.err != rfa_pkg::ERR_NONE)
    begin
      ptr_we = 1'b0;
      nxt_status.cnt = 8'h00;
      nxt_status.rec = rfa_pkg::REC_NONE;
      nxt_status.renum = 1'b0;
    end
    nxt_status.ok = nxt_status.err == rfa_pkg::ERR_NONE;
    nxt_status.done = 1'b1;
  end

  // pointer per file; clearing marks every pointer as never set
  always_ff @(posedge aclk)
  begin
    if (!aresetn || exec_clr)
    begin
      for (int i = 0; i < 32; i++)
      begin
        ptr_mem_ff[i] <= rfa_pkg::REC_NONE;
      end
    end
    else if (exec_go && ptr_we)
    begin
      ptr_mem_ff[fid] <= nxt_status.rec;
    end
  end

  // results land in the go cycle, so a poll after the write response sees them
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_ff <= rfa_pkg::STATUS_RST;
      offs_ff <= rfa_pkg::OFFS_RST;
      found_ff <= 32'h0000_0000;
    end
    else if (exec_go)
    begin
      status_ff <= nxt_status;
      offs_ff <= nxt_offs;
      if (cmd_ff.op == rfa_pkg::OP_SEARCH)
      begin
        found_ff <= hits_v;
      end
    end
  end

  // guards on pointer and result, one cycle after each go
  chk_fail_ptr_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_go && !exec_clr && cmd_ff.op != rfa_pkg::OP_UPD_BIN && !nxt_status.ok
    |=> ptr_mem_ff[status_ff.fid] == $past(cur_ptr)) else $error("pointer moved on refusal");
  chk_abs_ptr_still: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_go && !exec_clr && mode == rfa_pkg::MODE_ABS
    && (cmd_ff.op == rfa_pkg::OP_READ_REC || cmd_ff.op == rfa_pkg::OP_UPD_REC)
    |=> ptr_mem_ff[status_ff.fid] == $past(cur_ptr)) else $error("absolute access moved pointer");
  chk_next_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_go && cmd_ff.op == rfa_pkg::OP_READ_REC && mode == rfa_pkg::MODE_NEXT && file_ff.cyclic
    && file_ff.rd_ok && fid != rfa_pkg::SFI_RFU && cur_ptr == file_ff.nrec
    |=> status_ff.rec == rfa_pkg::REC_FIRST) else $error("cyclic next did not wrap");
  chk_prev_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_go && cmd_ff.op == rfa_pkg::OP_READ_REC && mode == rfa_pkg::MODE_PREV && file_ff.cyclic
    && file_ff.rd_ok && fid != rfa_pkg::SFI_RFU && cur_ptr == rfa_pkg::REC_FIRST
    |=> status_ff.rec == $past(file_ff.nrec)) else $error("cyclic previous did not wrap");
  chk_cyclic_upd_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_go && cmd_ff.op == rfa_pkg::OP_UPD_REC && file_ff.cyclic && mode != rfa_pkg::MODE_PREV
    |=> !status_ff.ok) else $error("cyclic update accepted outside previous");
  chk_bad_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_go && (cmd_ff.op == rfa_pkg::OP_READ_REC || cmd_ff.op == rfa_pkg::OP_UPD_REC)
    && mode != rfa_pkg::MODE_NEXT && mode != rfa_pkg::MODE_PREV && mode != rfa_pkg::MODE_ABS
    |=> !status_ff.ok) else $error("unknown mode accepted");
  chk_search_count: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_go && cmd_ff.op == rfa_pkg::OP_SEARCH
    |=> status_ff.cnt <= $past(cmd_ff.len)) else $error("search count above length");
endmodule : rfa_engine

// ---- dv/rfa_term.sv ----
// terminal model: issues file access commands through the register port
module rfa_term (
  input wire logic aclk, // bus clock
  output logic [7:0] s_axi_awaddr, // write address
  output logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address taken
  output logic [31:0] s_axi_wdata, // write data
  output logic [3:0] s_axi_wstrb, // byte enables
  output logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data taken
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // write response valid
  output logic s_axi_bready, // write response taken
  output logic [7:0] s_axi_araddr, // read address
  output logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address taken
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read data valid
  output logic s_axi_rready // read data taken
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    logic b;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    {aw, w, b} = 3'b111;
    while (aw | w | b)
    begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1)
      begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1)
      begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (b && s_axi_bvalid === 1'b1)
      begin
        b = 1'b0;
        s_axi_bready <= 1'b0;
      end
    end
  endtask : wr
  // read data taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic r;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    r = 1'b1;
    while (r)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        d = s_axi_rdata;
        r = 1'b0;
        s_axi_rready <= 1'b0;
      end
    end
  endtask : rd
  // next and previous always carry a zero record number
  task automatic send_cmd(input rfa_pkg::rfa_op_t op, input logic [2:0] m, input logic [7:0] p1);
    rfa_pkg::rfa_cmd_t c;
    c = '{op: op, len: 8'h04, p2: {rfa_pkg::SFI_CURRENT, m}, p1: p1};
    if (m != rfa_pkg::MODE_ABS) c.p1 = 8'h00;
    wr(rfa_pkg::ADDR_CMD, {6'h00, c});
    wr(rfa_pkg::ADDR_CTRL, 32'h0000_0001 << rfa_pkg::CTRL_GO_BIT);
  endtask : send_cmd
endmodule : rfa_term

// ---- dv/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int miscompares = 0;
  int total_checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial
  begin
    forever #10 aclk = ~aclk;
  end
  rfa_engine rfa_engine_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  rfa_term term_i (.aclk(aclk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  // file shape, then pointer cleared so it counts as never set
  task automatic set_file(input logic cyc, input logic rok, input logic uok);
    rfa_pkg::rfa_file_t f;
    f = '{ind: 8'h00, cur_fid: 5'h00, upd_ok: uok, rd_ok: rok, cyclic: cyc, nrec: 8'h04};
    term_i.wr(rfa_pkg::ADDR_FILE, {8'h00, f});
    term_i.wr(rfa_pkg::ADDR_CTRL, 32'h0000_0001 << rfa_pkg::CTRL_CLR_BIT);
  endtask : set_file
  // run one command and poll for completion, bounded
  task automatic exec(input rfa_pkg::rfa_op_t op, input logic [2:0] m, input logic [7:0] p1,
                      output rfa_pkg::rfa_status_t st);
    logic [31:0] d;
    int n;
    term_i.send_cmd(op, m, p1);
    n = 0;
    st = '0;
    while (st.done !== 1'b1 && n < 200)
    begin
      term_i.rd(rfa_pkg::ADDR_STATUS, d);
      st = d[26:0];
      n++;
    end
    if (n == 200) miscompares++;
  endtask : exec
  task automatic chk_ptr(input logic [7:0] exp);
    logic [31:0] d;
    term_i.rd(rfa_pkg::ADDR_PTR, d);
    check({24'h0, d[7:0]}, {24'h0, exp});
  endtask : chk_ptr
  ////////////////////////////////////////////////////////////////////////////////
  // linear: first next read, stuck previous, absolute read
  task automatic t_linear_fwd;
    rfa_pkg::rfa_status_t s;
    set_file(1'b0, 1'b1, 1'b1);
    exec(rfa_pkg::OP_READ_REC, rfa_pkg::MODE_NEXT, 8'h00, s);
    check({24'h0, s.rec}, 32'h0000_0001);
    exec(rfa_pkg::OP_READ_REC, rfa_pkg::MODE_PREV, 8'h00, s);
    check(32'(s.ok), 32'h0000_0000);
    chk_ptr(8'h01);
    exec(rfa_pkg::OP_READ_REC, rfa_pkg::MODE_ABS, 8'h03, s);
    check({24'h0, s.rec}, 32'h0000_0003);
    chk_ptr(8'h01);
  endtask : t_linear_fwd
  // linear: previous from unset lands on last, then next and next-update stop
  task automatic t_linear_back;
    rfa_pkg::rfa_status_t s;
    set_file(1'b0, 1'b1, 1'b1);
    exec(rfa_pkg::OP_READ_REC, rfa_pkg::MODE_PREV, 8'h00, s);
    check({24'h0, s.rec}, 32'h0000_0004);
    exec(rfa_pkg::OP_READ_REC, rfa_pkg::MODE_NEXT, 8'h00, s);
    check(32'(s.ok), 32'h0000_0000);
    exec(rfa_pkg::OP_UPD_REC, rfa_pkg::MODE_NEXT, 8'h00, s);
    check(32'(s.ok), 32'h0000_0000);
    chk_ptr(8'h04);
  endtask : t_linear_back
  // cyclic: wrap both ways, next-update refused
  task automatic t_cyclic;
    rfa_pkg::rfa_status_t s;
    set_file(1'b1, 1'b1, 1'b1);
    exec(rfa_pkg::OP_READ_REC, rfa_pkg::MODE_PREV, 8'h00, s);
    exec(rfa_pkg::OP_READ_REC, rfa_pkg::MODE_NEXT, 8'h00, s);
    check({24'h0, s.rec}, 32'h0000_0001);
    exec(rfa_pkg::OP_READ_REC, rfa_pkg::MODE_PREV, 8'h00, s);
    check({24'h0, s.rec}, 32'h0000_0004);
    exec(rfa_pkg::OP_UPD_REC, rfa_pkg::MODE_NEXT, 8'h00, s);
    check(32'(s.err), 32'(rfa_pkg::ERR_NOT_PERM));
    chk_ptr(8'h04);
  endtask : t_cyclic
  // missing read right, then an unknown mode code
  task automatic t_refusals;
    rfa_pkg::rfa_status_t s;
    set_file(1'b0, 1'b0, 1'b1);
    exec(rfa_pkg::OP_READ_REC, rfa_pkg::MODE_NEXT, 8'h00, s);
    check(32'(s.ok), 32'h0000_0000);
    chk_ptr(rfa_pkg::REC_NONE);
    set_file(1'b0, 1'b1, 1'b1);
    exec(rfa_pkg::OP_READ_REC, 3'h0, 8'h00, s);
    check(32'(s.err), 32'(rfa_pkg::ERR_MODE));
    chk_ptr(rfa_pkg::REC_NONE);
  endtask : t_refusals
  // cyclic oldest-record update, forward search, binary update offset
  task automatic t_search_upd;
    rfa_pkg::rfa_status_t s;
    logic [31:0] d;
    set_file(1'b1, 1'b1, 1'b1);
    exec(rfa_pkg::OP_UPD_REC, rfa_pkg::MODE_PREV, 8'h00, s);
    check({31'h0, s.renum}, 32'h0000_0001);
    chk_ptr(8'h01);
    term_i.wr(rfa_pkg::ADDR_HITS, 32'h0000_0016);
    exec(rfa_pkg::OP_SEARCH, rfa_pkg::MODE_ABS, 8'h01, s);
    check({24'h0, s.cnt}, 32'h0000_0002);
    chk_ptr(8'h02);
    exec(rfa_pkg::OP_UPD_BIN, rfa_pkg::MODE_ABS, 8'h85, s);
    term_i.rd(rfa_pkg::ADDR_OFFS, d);
    check(d, 32'h0012_8004);
  endtask : t_search_upd
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_linear_fwd();
    t_linear_back();
    t_cyclic();
    t_refusals();
    t_search_upd();
    complete_run();
  end
  // watchdog well beyond the expected few hundred cycles
  initial
  begin
    repeat (50000) @(posedge aclk);
    miscompares++;
    complete_run();
  end
endmodule : tb_top
